/* srd_defines.svh */
// constants for the scanner read command block
`ifndef SRD_DEFINES_SVH
`define SRD_DEFINES_SVH

// command block layout
`define SRD_CDB_LEN 4'd10
`define SRD_OPC_READ 8'h28
`define SRD_IDX_OPC 0
`define SRD_IDX_PAYLOAD 2
`define SRD_IDX_TSEL_HI 4
`define SRD_IDX_TSEL_LO 5
`define SRD_IDX_LEN_MSB 6
`define SRD_IDX_LEN_MID 7
`define SRD_IDX_LEN_LSB 8

// payload selector and transfer selector codes
`define SRD_SEL_IMAGE 8'h00
`define SRD_SEL_MATRIX 8'h01
`define SRD_SEL_GAMMA 8'h03
`define SRD_SEL_SHADING 8'h80
`define SRD_TSEL_IMAGE 8'h00
`define SRD_TSEL_TABLE 8'h02

// table sizes and bases in the table memory
`define SRD_MATRIX_SIZE 24'h00_0012
`define SRD_GAMMA_SIZE 24'h00_0300
`define SRD_SHADING_SIZE 24'h00_1FA4
`define SRD_MATRIX_BASE 14'h0000
`define SRD_GAMMA_BASE 14'h0012
`define SRD_SHADING_BASE 14'h0312
`define SRD_TBL_DEPTH 8886

// status byte and sense keys
`define SRD_STS_GOOD 8'h00
`define SRD_STS_CHECK 8'h02
`define SRD_SENSE_NONE 4'h0
`define SRD_SENSE_ILLEGAL 4'h5

// register offsets
`define SRD_REG_CTRL 12'h000
`define SRD_REG_WIDTH 12'h004
`define SRD_REG_LINE_PIX 12'h008
`define SRD_REG_LINE_BYTES 12'h00C
`define SRD_REG_IRQ_STATUS 12'h010
`define SRD_REG_IRQ_ENABLE 12'h014
`define SRD_REG_IRQ_CLEAR 12'h018
`define SRD_REG_SENSE 12'h01C
`define SRD_REG_TBL_ADDR 12'h020
`define SRD_REG_TBL_DATA 12'h024

// control and interrupt fields and reset values
`define SRD_CTRL_COLOUR 0
`define SRD_CTRL_DEPTH_LO 1
`define SRD_CTRL_DEPTH_HI 2
`define SRD_CTRL_RESET 3'h0
`define SRD_WIDTH_RESET 16'h0000
`define SRD_IRQ_DONE 0
`define SRD_IRQ_CHECK 1
`define SRD_IRQ_FOREIGN 2

`endif

/* srd_pkg.sv */
// types shared by the scanner read command block
package srd_pkg;
  // engine states, one-hot
  typedef enum logic [3:0] {
    SRD_IDLE = 4'b0001,
    SRD_DECODE = 4'b0010,
    SRD_DATA = 4'b0100,
    SRD_STATUS = 4'b1000
  } srd_state_t;

  // data source of a read
  typedef enum logic [1:0] {
    SRD_SRC_IMAGE = 2'd0,
    SRD_SRC_MATRIX = 2'd1,
    SRD_SRC_GAMMA = 2'd2,
    SRD_SRC_SHADING = 2'd3
  } srd_src_t;

  // pixel depth codes of the control register
  typedef enum logic [1:0] {
    SRD_DEPTH_1 = 2'd0,
    SRD_DEPTH_4 = 2'd1,
    SRD_DEPTH_8 = 2'd2
  } srd_depth_t;
endpackage : srd_pkg

/* srd_cdb_parser.sv */
// collector of the ten-byte command block
`timescale 1ns/1ps
`include "srd_defines.svh"
module srd_cdb_parser (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // command bytes from the bus phase logic
  input wire logic cdb_valid,
  input wire logic [7:0] cdb_byte,
  output logic cdb_ready,
  // collected block towards the engine
  output logic cdb_full,
  input wire logic cdb_release,
  output logic [7:0] cdb_bytes [0:9]
);
  logic [3:0] idx_ff;
  logic full_ff;
  logic take;

  // a full block stalls the byte source until the engine lets it go
  assign cdb_ready = !full_ff;
  assign take = cdb_valid && !full_ff;
  assign cdb_full = full_ff;

  // byte counter and full flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idx_ff <= 4'd0;
      full_ff <= 1'b0;
    end else if (cdb_release) begin
      idx_ff <= 4'd0;
      full_ff <= 1'b0;
    end else if (take) begin
      idx_ff <= idx_ff + 4'd1;
      full_ff <= (idx_ff == `SRD_CDB_LEN - 4'd1);
    end
  end

  // one holding byte per command block position
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_byte
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          cdb_bytes[gi] <= 8'h00;
        end else if (take && idx_ff == 4'(gi)) begin
          cdb_bytes[gi] <= cdb_byte;
        end
      end
    end
  endgenerate
endmodule : srd_cdb_parser

/* srd_table_mem.sv */
// byte memory for matrix, gamma and shading tables
`timescale 1ns/1ps
`include "srd_defines.svh"
module srd_table_mem (
  // clock
  input wire logic clk_sys,
  // write port from software
  input wire logic wr_en,
  input wire logic [13:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port for the engine
  input wire logic [13:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:`SRD_TBL_DEPTH-1];

  // writes beyond the last table are dropped
  always_ff @(posedge clk_sys) begin
    if (wr_en && wr_addr < 14'(`SRD_TBL_DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // unregistered read keeps the engine free of a fetch latency
  assign rd_data = (rd_addr < 14'(`SRD_TBL_DEPTH)) ? mem[rd_addr] : 8'h00;
endmodule : srd_table_mem

/* srd_read_cmd.sv */
// read command interpreter of the scanner target
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`include "srd_defines.svh"
module srd_read_cmd (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command bytes from the bus phase logic
  input wire logic cdb_valid,
  input wire logic [7:0] cdb_byte,
  output logic cdb_ready,
  // image bytes from the scan buffer
  input wire logic img_valid,
  input wire logic [7:0] img_byte,
  output logic img_ready,
  input wire logic [23:0] img_avail,
  // data in towards the host
  output logic data_valid,
  output logic [7:0] data_byte,
  input wire logic data_ready,
  // status phase
  output logic status_valid,
  output logic [7:0] status_code,
  output logic foreign_cmd,
  // sense data
  output logic [3:0] sense_key,
  input wire logic sense_taken,
  // interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  srd_pkg::srd_state_t state_ff;
  srd_pkg::srd_state_t nxt_state;
  srd_pkg::srd_src_t src_ff;
  srd_pkg::srd_src_t nxt_src;
  logic [7:0] cdb_bytes [0:9];
  logic cdb_full;
  logic cdb_release;
  logic [23:0] alloc_len;
  logic [23:0] held_len;
  logic [23:0] send_len;
  logic sel_ok;
  logic reject;
  logic [23:0] remain_ff;
  logic [13:0] tbl_ptr_ff;
  logic [13:0] nxt_base;
  logic [7:0] tbl_rd_data;
  logic out_valid_ff;
  logic [7:0] out_byte_ff;
  logic src_has;
  logic load;
  logic drained;
  logic [7:0] status_ff;
  logic [3:0] sense_ff;
  logic [2:0] ctrl_ff;
  logic [15:0] width_ff;
  logic [16:0] line_pix;
  logic [16:0] plane_bytes;
  logic [18:0] line_bytes;
  logic [2:0] irq_status_ff;
  logic [2:0] irq_enable_ff;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [13:0] tbl_addr_ff;
  logic tbl_wr;
  logic apb_setup;
  logic apb_wr;
  logic [31:0] rd_word;
  logic rd_err;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // command block collection and field extraction
  srd_cdb_parser u_parser (
    .clk_sys(clk_sys),
    .rst(rst),
    .cdb_valid(cdb_valid),
    .cdb_byte(cdb_byte),
    .cdb_ready(cdb_ready),
    .cdb_full(cdb_full),
    .cdb_release(cdb_release),
    .cdb_bytes(cdb_bytes)
  );

  assign alloc_len = {cdb_bytes[`SRD_IDX_LEN_MSB],
                      cdb_bytes[`SRD_IDX_LEN_MID],
                      cdb_bytes[`SRD_IDX_LEN_LSB]};
  // the block is handed back as soon as it is decoded
  assign cdb_release = (state_ff == srd_pkg::SRD_DECODE);

  ////////////////////////////////////////////////////////////////////////////
  // source selection
  // reserved bytes and the first selector byte are trusted to be zero,
  // so only the pairing of payload and second selector byte is checked
  always_comb begin
    nxt_src = srd_pkg::SRD_SRC_IMAGE;
    nxt_base = `SRD_MATRIX_BASE;
    held_len = 24'h00_0000;
    sel_ok = 1'b0;
    if (cdb_bytes[`SRD_IDX_PAYLOAD] == `SRD_SEL_IMAGE) begin
      nxt_src = srd_pkg::SRD_SRC_IMAGE;
      held_len = img_avail;
      sel_ok = (cdb_bytes[`SRD_IDX_TSEL_LO] == `SRD_TSEL_IMAGE);
    end else if (cdb_bytes[`SRD_IDX_PAYLOAD] == `SRD_SEL_MATRIX) begin
      nxt_src = srd_pkg::SRD_SRC_MATRIX;
      nxt_base = `SRD_MATRIX_BASE;
      held_len = `SRD_MATRIX_SIZE;
      sel_ok = (cdb_bytes[`SRD_IDX_TSEL_LO] == `SRD_TSEL_TABLE);
    end else if (cdb_bytes[`SRD_IDX_PAYLOAD] == `SRD_SEL_GAMMA) begin
      nxt_src = srd_pkg::SRD_SRC_GAMMA;
      nxt_base = `SRD_GAMMA_BASE;
      held_len = `SRD_GAMMA_SIZE;
      sel_ok = (cdb_bytes[`SRD_IDX_TSEL_LO] == `SRD_TSEL_TABLE);
    end else if (cdb_bytes[`SRD_IDX_PAYLOAD] == `SRD_SEL_SHADING) begin
      nxt_src = srd_pkg::SRD_SRC_SHADING;
      nxt_base = `SRD_SHADING_BASE;
      held_len = `SRD_SHADING_SIZE;
      sel_ok = (cdb_bytes[`SRD_IDX_TSEL_LO] == `SRD_TSEL_TABLE);
    end
  end

  assign reject = !sel_ok ||
                  (nxt_src == srd_pkg::SRD_SRC_IMAGE && alloc_len[0]);
  // lesser of limit and held data
  assign send_len = (alloc_len < held_len) ? alloc_len : held_len;

  ////////////////////////////////////////////////////////////////////////////
  // engine state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      srd_pkg::SRD_IDLE: begin
        if (cdb_full) begin
          nxt_state = srd_pkg::SRD_DECODE;
        end
      end
      srd_pkg::SRD_DECODE: begin
        if (cdb_bytes[`SRD_IDX_OPC] != `SRD_OPC_READ) begin
          nxt_state = srd_pkg::SRD_IDLE;
        end else if (reject || send_len == 24'h00_0000) begin
          // empty read goes straight to status
          nxt_state = srd_pkg::SRD_STATUS;
        end else begin
          nxt_state = srd_pkg::SRD_DATA;
        end
      end
      srd_pkg::SRD_DATA: begin
        if (remain_ff == 24'h00_0000 && drained) begin
          nxt_state = srd_pkg::SRD_STATUS;
        end
      end
      srd_pkg::SRD_STATUS: begin
        nxt_state = srd_pkg::SRD_IDLE;
      end
      default: begin
        nxt_state = srd_pkg::SRD_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= srd_pkg::SRD_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data phase: one output register, filled when empty or being drained
  assign src_has = (src_ff == srd_pkg::SRD_SRC_IMAGE) ? img_valid : 1'b1;
  assign drained = !out_valid_ff || data_ready;
  assign load = (state_ff == srd_pkg::SRD_DATA) &&
                (remain_ff != 24'h00_0000) && drained && src_has;
  assign img_ready = load && (src_ff == srd_pkg::SRD_SRC_IMAGE);

  // remaining count, source and table pointer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      remain_ff <= 24'h00_0000;
      src_ff <= srd_pkg::SRD_SRC_IMAGE;
      tbl_ptr_ff <= 14'h0000;
    end else if (state_ff == srd_pkg::SRD_DECODE) begin
      // count loaded with the lesser length, or with zero on a refused read
      remain_ff <= reject ? 24'h00_0000 : send_len;
      src_ff <= nxt_src;
      tbl_ptr_ff <= nxt_base;
    end else if (load) begin
      remain_ff <= remain_ff - 24'h00_0001;
      tbl_ptr_ff <= tbl_ptr_ff + 14'h0001;
    end
  end

  // output byte register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_valid_ff <= 1'b0;
      out_byte_ff <= 8'h00;
    end else if (load) begin
      out_valid_ff <= 1'b1;
      out_byte_ff <= (src_ff == srd_pkg::SRD_SRC_IMAGE) ? img_byte
                                                        : tbl_rd_data;
    end else if (data_ready) begin
      out_valid_ff <= 1'b0;
    end
  end

  assign data_valid = out_valid_ff;
  assign data_byte = out_byte_ff;

  ////////////////////////////////////////////////////////////////////////////
  // status byte and sense key
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_ff <= `SRD_STS_GOOD;
    end else if (state_ff == srd_pkg::SRD_DECODE) begin
      // check condition on a refused read
      status_ff <= reject ? `SRD_STS_CHECK : `SRD_STS_GOOD;
    end
  end

  // a new refusal wins over a sense report finishing in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sense_ff <= `SRD_SENSE_NONE;
    end else if (state_ff == srd_pkg::SRD_DECODE &&
                 cdb_bytes[`SRD_IDX_OPC] == `SRD_OPC_READ && reject) begin
      sense_ff <= `SRD_SENSE_ILLEGAL;
    end else if (sense_taken) begin
      sense_ff <= `SRD_SENSE_NONE;
    end
  end

  assign status_valid = (state_ff == srd_pkg::SRD_STATUS);
  assign status_code = status_ff;
  assign foreign_cmd = (state_ff == srd_pkg::SRD_DECODE) &&
                       (cdb_bytes[`SRD_IDX_OPC] != `SRD_OPC_READ);
  assign sense_key = sense_ff;

  ////////////////////////////////////////////////////////////////////////////
  // scan line geometry seen by software
  // lines rounded to even bytes
  always_comb begin
    line_pix = {1'b0, width_ff};
    plane_bytes = {1'b0, width_ff};
    case (srd_pkg::srd_depth_t'(ctrl_ff[`SRD_CTRL_DEPTH_HI:
                                        `SRD_CTRL_DEPTH_LO]))
      srd_pkg::SRD_DEPTH_1: begin
        line_pix = ({1'b0, width_ff} + 17'h0_000F) & 17'h1_FFF0;
        plane_bytes = line_pix >> 3;
      end
      srd_pkg::SRD_DEPTH_4: begin
        line_pix = ({1'b0, width_ff} + 17'h0_0003) & 17'h1_FFFC;
        plane_bytes = line_pix >> 1;
      end
      default: begin
        line_pix = ({1'b0, width_ff} + 17'h0_0001) & 17'h1_FFFE;
        plane_bytes = line_pix;
      end
    endcase
  end

  // colour lines carry three padded planes
  assign line_bytes = ctrl_ff[`SRD_CTRL_COLOUR] ?
                      19'({2'b00, plane_bytes} * 19'h0_0003) :
                      {2'b00, plane_bytes};

  ////////////////////////////////////////////////////////////////////////////
  // table memory, loaded by software through an address and data pair
  // software must not load a table while a read of it is running
  srd_table_mem u_tables (
    .clk_sys(clk_sys),
    .wr_en(tbl_wr),
    .wr_addr(tbl_addr_ff),
    .wr_data(pwdata[7:0]),
    .rd_addr(tbl_ptr_ff),
    .rd_data(tbl_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, read word captured in the setup cycle
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign tbl_wr = apb_wr && (paddr == `SRD_REG_TBL_DATA);
  assign irq_clr = (apb_wr && paddr == `SRD_REG_IRQ_CLEAR) ?
                   pwdata[2:0] : 3'b000;

  // read decode; unmapped addresses answer zero with an error
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == `SRD_REG_CTRL) begin
      rd_word = {29'h0000_0000, ctrl_ff};
    end else if (paddr == `SRD_REG_WIDTH) begin
      rd_word = {16'h0000, width_ff};
    end else if (paddr == `SRD_REG_LINE_PIX) begin
      rd_word = {15'h0000, line_pix};
    end else if (paddr == `SRD_REG_LINE_BYTES) begin
      rd_word = {13'h0000, line_bytes};
    end else if (paddr == `SRD_REG_IRQ_STATUS) begin
      rd_word = {29'h0000_0000, irq_status_ff};
    end else if (paddr == `SRD_REG_IRQ_ENABLE) begin
      rd_word = {29'h0000_0000, irq_enable_ff};
    end else if (paddr == `SRD_REG_IRQ_CLEAR) begin
      rd_word = 32'h0000_0000;
    end else if (paddr == `SRD_REG_SENSE) begin
      rd_word = {28'h000_0000, sense_ff};
    end else if (paddr == `SRD_REG_TBL_ADDR) begin
      rd_word = {18'h0_0000, tbl_addr_ff};
    end else if (paddr == `SRD_REG_TBL_DATA) begin
      rd_word = 32'h0000_0000;
    end else begin
      rd_err = 1'b1;
    end
  end

  // read data and error flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (apb_setup) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_ff <= rd_err;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff && psel && penable;

  // writable configuration
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_ff <= `SRD_CTRL_RESET;
      width_ff <= `SRD_WIDTH_RESET;
      irq_enable_ff <= 3'b000;
      tbl_addr_ff <= 14'h0000;
    end else if (apb_wr) begin
      if (paddr == `SRD_REG_CTRL) begin
        ctrl_ff <= pwdata[2:0];
      end else if (paddr == `SRD_REG_WIDTH) begin
        width_ff <= pwdata[15:0];
      end else if (paddr == `SRD_REG_IRQ_ENABLE) begin
        irq_enable_ff <= pwdata[2:0];
      end else if (paddr == `SRD_REG_TBL_ADDR) begin
        tbl_addr_ff <= pwdata[13:0];
      end else if (paddr == `SRD_REG_TBL_DATA) begin
        tbl_addr_ff <= tbl_addr_ff + 14'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt status; a new event wins over a clear
  always_comb begin
    irq_set = 3'b000;
    irq_set[`SRD_IRQ_DONE] = status_valid && (status_ff == `SRD_STS_GOOD);
    irq_set[`SRD_IRQ_CHECK] = status_valid && (status_ff == `SRD_STS_CHECK);
    irq_set[`SRD_IRQ_FOREIGN] = foreign_cmd;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_status_ff <= 3'b000;
    end else begin
      irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_status_ff & irq_enable_ff);
endmodule : srd_read_cmd

/* srd_read_cmd_asserts.sv */
// checker for the read command interpreter ports
`timescale 1ns/1ps
module srd_read_cmd_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb answer
  input wire logic psel,
  input wire logic pready,
  // command and data
  input wire logic cdb_valid,
  input wire logic cdb_ready,
  input wire logic img_valid,
  input wire logic img_ready,
  input wire logic data_valid,
  input wire logic data_ready,
  input wire logic [7:0] data_byte,
  // status and sense
  input wire logic status_valid,
  input wire logic [7:0] status_code,
  input wire logic foreign_cmd,
  input wire logic [3:0] sense_key,
  input wire logic sense_taken
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [3:0] cnt_ff;
  ////////////////////////////////////////////////////////////////////////
  // bytes taken in the current block, wraps after the tenth
  always_ff @(posedge clk_sys) begin
    if (rst)
      cnt_ff <= 4'h0;
    else if (cdb_valid && cdb_ready)
      cnt_ff <= (cnt_ff == 4'h9) ? 4'h0 : cnt_ff + 4'h1;
  end
  AST_CDB_FULL:
    assert property (cdb_valid && cdb_ready && cnt_ff == 4'h9 |=> !cdb_ready)
    else $error("block still open after ten bytes");
  AST_REFUSE_NODATA:
    assert property (status_valid && status_code == 8'h02 |-> !$past(cdb_ready))
    else $error("check status not right after decode");
  AST_SENSE_SET:
    assert property (status_valid && status_code == 8'h02 |-> sense_key == 4'h5)
    else $error("sense key not five on check status");
  AST_SENSE_CLR:
    assert property (sense_taken |=> sense_key == 4'h0 || status_valid)
    else $error("sense key kept after request sense");
  AST_DATA_HOLD:
    assert property (data_valid && !data_ready |=> data_valid && $stable(data_byte))
    else $error("data byte dropped before taken");
  AST_STATUS_END:
    assert property (status_valid |-> !data_valid ##1 !status_valid)
    else $error("status overlaps data or lasts two cycles");
  AST_FOREIGN:
    assert property (foreign_cmd |-> !status_valid ##1 !foreign_cmd)
    else $error("foreign block answered");
  AST_IMG_TAKE:
    assert property (img_ready |-> img_valid && !status_valid)
    else $error("image byte taken while not offered");
  AST_PREADY:
    assert property (psel |-> pready)
    else $error("apb wait state seen");
  cover property (data_valid && data_ready ##1 status_valid);
  cover property (status_valid && status_code == 8'h02);
  cover property (foreign_cmd);
endmodule : srd_read_cmd_asserts

bind srd_read_cmd srd_read_cmd_asserts srd_read_cmd_asserts_i (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .pready(pready),
  .cdb_valid(cdb_valid), .cdb_ready(cdb_ready), .img_valid(img_valid),
  .img_ready(img_ready), .data_valid(data_valid), .data_ready(data_ready),
  .data_byte(data_byte), .status_valid(status_valid),
  .status_code(status_code), .foreign_cmd(foreign_cmd),
  .sense_key(sense_key), .sense_taken(sense_taken));

/* srd_host_model.sv */
// host initiator model: sends command blocks, takes data
`timescale 1ns/1ps
module srd_host_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bench control
  input wire logic go,
  input wire logic [79:0] cmd,
  input wire logic stall,
  // command bytes
  output logic cdb_valid,
  output logic [7:0] cdb_byte,
  input wire logic cdb_ready,
  // data in
  output logic data_ready
);
  logic [3:0] idx_ff;
  logic [79:0] blk_ff;
  ////////////////////////////////////////////////////////////////////////
  // bytes in block order
  // a released byte line shows the inverse so stale data never matches
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cdb_valid <= 1'b0;
      cdb_byte <= 8'h00;
      idx_ff <= 4'h0;
    end else if (go && !cdb_valid) begin
      blk_ff <= cmd;
      idx_ff <= 4'h0;
      cdb_valid <= 1'b1;
      cdb_byte <= cmd[79:72];
    end else if (cdb_valid && cdb_ready) begin
      idx_ff <= idx_ff + 4'h1;
      cdb_valid <= (idx_ff != 4'h9);
      cdb_byte <= (idx_ff == 4'h9) ? ~cdb_byte : blk_ff[71 - 8 * idx_ff -: 8];
    end
  end
  // host may stall the data phase at any cycle
  assign data_ready = !stall;
endmodule : srd_host_model

/* srd_read_cmd_bench.sv */
// self-checking bench of the read command interpreter
`timescale 1ns/1ps
`include "srd_defines.svh"
module srd_read_cmd_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic cdb_valid, cdb_ready, img_ready, data_valid, data_ready;
  logic [7:0] cdb_byte, data_byte, status_code;
  logic img_valid = 1'b0, stall = 1'b0, go = 1'b0, sense_taken = 1'b0;
  logic [7:0] img_byte = 8'h00;
  logic [23:0] img_avail = 24'h00_0000;
  logic [79:0] cmd = 80'h0;
  logic status_valid, foreign_cmd, irq;
  logic [3:0] sense_key;
  logic [7:0] eq[$], sq[$];
  int mismatches = 0, comparisons = 0, cyc = 0, ndata = 0, nfor = 0;
  int seed = 32'h070f_4e8f;
  int d, w, px, bt;

  always #12.5 clk_sys = ~clk_sys;

  srd_read_cmd srd_read_cmd_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cdb_valid(cdb_valid), .cdb_byte(cdb_byte), .cdb_ready(cdb_ready),
    .img_valid(img_valid), .img_byte(img_byte), .img_ready(img_ready),
    .img_avail(img_avail), .data_valid(data_valid), .data_byte(data_byte),
    .data_ready(data_ready), .status_valid(status_valid),
    .status_code(status_code), .foreign_cmd(foreign_cmd),
    .sense_key(sense_key), .sense_taken(sense_taken), .irq(irq));
  srd_host_model srd_host_model_i (.clk_sys(clk_sys), .rst(rst), .go(go),
    .cmd(cmd), .stall(stall), .cdb_valid(cdb_valid), .cdb_byte(cdb_byte),
    .cdb_ready(cdb_ready), .data_ready(data_ready));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    apb(1'b1, a, wd, x);
  endtask : wr

  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    apb(1'b0, a, 32'h0000_0000, x);
    chk(n, e, x);
  endtask : rc

  // table contents chosen so neighbouring bytes differ
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 7 + (i >> 8));
  endfunction : pat

  // send one block, note expectations, wait for the answer
  task automatic run(input logic [7:0] op, sel, ts, input logic [23:0] lim,
                     input int n, input int base, input logic [7:0] st);
    int n0, f0;
    n0 = ndata;
    f0 = nfor;
    for (int i = 0; i < n && sel != 8'h00; i++) eq.push_back(pat(base + i));
    if (op == `SRD_OPC_READ) sq.push_back(st);
    cmd <= {op, 8'h00, sel, 8'h00, 8'h00, ts, lim, 8'h00};
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    // a hang here is ended by the cycle guard as a mismatch
    while (sq.size() || eq.size() || (op != `SRD_OPC_READ && nfor == f0))
      @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    chk("byte count", n, ndata - n0);
    $display("test op %h sel %h limit %0d done", op, sel, lim);
  endtask : run

  // image source and host stalls, both random
  always @(posedge clk_sys) begin
    if (img_valid === 1'b1 && img_ready === 1'b1)
      eq.push_back(img_byte);
    img_valid <= 1'($random(seed));
    img_byte <= 8'($random(seed));
    stall <= 1'($random(seed));
  end

  // compare each byte taken and each status against the oldest note
  always @(posedge clk_sys) begin
    if (data_valid === 1'b1 && data_ready === 1'b1) begin
      ndata++;
      chk("data byte", eq.size() ? eq.pop_front() : 8'hxx, data_byte);
    end
    if (status_valid === 1'b1)
      chk("status", sq.size() ? sq.pop_front() : 8'hxx, status_code);
    if (foreign_cmd === 1'b1)
      nfor++;
  end

  // hang guard, well above the longest expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rc("sense", `SRD_REG_SENSE, 32'h0000_0000);
    rc("unmapped", 12'h100, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, {31'h0, err});
    // padded line sizes, mono then colour
    for (int k = 0; k < 6; k++) begin
      d = k % 3;
      w = 1 + ($random(seed) & 255);
      bt = (d == 0) ? 1 : (d == 1) ? 4 : 8;
      px = (d == 0) ? 16 : (d == 1) ? 4 : 2;
      px = (w + px - 1) / px * px;
      wr(`SRD_REG_CTRL, {29'h0, 2'(d), k > 2});
      wr(`SRD_REG_WIDTH, 32'(w));
      rc("line pixels", `SRD_REG_LINE_PIX, px);
      rc("line bytes", `SRD_REG_LINE_BYTES, px * bt / 8 * (k > 2 ? 3 : 1));
    end
    $display("test padding done");
    wr(`SRD_REG_TBL_ADDR, 32'h0000_0000);
    for (int i = 0; i < `SRD_TBL_DEPTH; i++)
      wr(`SRD_REG_TBL_DATA, {24'h0, pat(i)});
    wr(`SRD_REG_IRQ_ENABLE, 32'h0000_0001);
    run(8'h28, 8'h01, 8'h02, 24'd18, 18, 0, 8'h00);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(`SRD_REG_IRQ_CLEAR, 32'h0000_0007);
    chk("irq cleared", 32'h0, {31'h0, irq});
    run(8'h28, 8'h03, 8'h02, 24'd768, 768, 18, 8'h00);
    run(8'h28, 8'h80, 8'h02, 24'd8100, 8100, 786, 8'h00);
    run(8'h28, 8'h01, 8'h02, 24'd20, 18, 0, 8'h00);
    run(8'h28, 8'h03, 8'h02, 24'd3, 3, 18, 8'h00);
    run(8'h28, 8'h03, 8'h02, 24'd0, 0, 18, 8'h00);
    wr(`SRD_REG_IRQ_CLEAR, 32'h0000_0007);
    run(8'h28, 8'h01, 8'h00, 24'd18, 0, 0, 8'h02);
    chk("irq masked", 32'h0, {31'h0, irq});
    rc("irq status", `SRD_REG_IRQ_STATUS, 32'h0000_0002);
    sense_taken <= 1'b1;
    @(posedge clk_sys);
    sense_taken <= 1'b0;
    @(posedge clk_sys);
    rc("sense clear", `SRD_REG_SENSE, 32'h0000_0000);
    img_avail <= 24'd6; // window scanned
    run(8'h28, 8'h00, 8'h00, 24'd10, 6, 0, 8'h00);
    img_avail <= 24'd100;
    run(8'h28, 8'h00, 8'h00, 24'd8, 8, 0, 8'h00);
    run(8'h28, 8'h00, 8'h00, 24'd7, 0, 0, 8'h02);
    rc("sense set", `SRD_REG_SENSE, 32'h0000_0005);
    wr(`SRD_REG_IRQ_CLEAR, 32'h0000_0007);
    run(8'h2a, 8'h00, 8'h00, 24'd4, 0, 0, 8'h00);
    rc("foreign", `SRD_REG_IRQ_STATUS, 32'h0000_0004);
    conclude();
  end
endmodule : srd_read_cmd_bench
